//--- rtl/diag_pkg.sv
// Package with register map, reset values and timing constants of the deterioration diagnosis block.
`default_nettype none
package diag_pkg;

  // Bus geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Byte offsets of the registers, one aligned word each.
  localparam logic [7:0] OFF_DYN_UP = 8'h00;
  localparam logic [7:0] OFF_DYN_LO = 8'h04;
  localparam logic [7:0] OFF_VISC_UP = 8'h08;
  localparam logic [7:0] OFF_VISC_LO = 8'h0C;
  localparam logic [7:0] OFF_SPEED_SET = 8'h10;
  localparam logic [7:0] OFF_AVG_TIME = 8'h14;
  localparam logic [7:0] OFF_TQ_UP = 8'h18;
  localparam logic [7:0] OFF_TQ_LO = 8'h1C;
  localparam logic [7:0] OFF_CONFIG = 8'h20;
  localparam logic [7:0] OFF_MATCH_W = 8'h24;
  localparam logic [7:0] OFF_STATUS = 8'h28;
  localparam logic [7:0] OFF_MASK = 8'h2C;
  localparam logic [7:0] OFF_STATE = 8'h30;

  // Number of plain 16-bit parameter registers at offsets 0x00 to 0x1C.
  localparam int NUM_PARAM = 8;

  // Reset values of the parameter, configuration, match width and mask registers.
  localparam logic [15:0] PARAM_RESET = 16'h0000;
  localparam logic [15:0] CONFIG_RESET = 16'h0000;
  localparam logic [15:0] MATCH_W_RESET = 16'h0000;
  localparam logic [3:0] MASK_RESET = 4'h0;

  // Field positions.
  localparam int CFG_DIAG_EN_BIT = 1;
  localparam int ST_DYN_BIT = 0;
  localparam int ST_VISC_BIT = 1;
  localparam int ST_TQ_BIT = 2;
  localparam int ST_WIN_BIT = 3;
  localparam int NUM_EVENTS = 4;

  // Timing: one averaging sample each millisecond.
  localparam int CLK_PERIOD_NS = 10;
  localparam int SAMPLE_PERIOD_NS = 1000000;
  localparam int CYCLES_PER_MS = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

  // Serial divider length in steps, one per dividend bit.
  localparam int DIV_STEPS = 32;

endpackage : diag_pkg
`default_nettype wire

//--- rtl/torque_averager.sv
// Torque command averager: sums one sample per millisecond tick and divides by the sample count.
`default_nettype none
module torque_averager
  import diag_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic tick_ms,
  input wire logic [15:0] time_ms,
  input wire logic signed [15:0] sample,
  output logic signed [15:0] avg,
  output logic avg_valid
);

  typedef enum logic {AV_ACC, AV_DIV} av_state_t;

  av_state_t state_reg, state_next; // Accumulating or dividing.
  logic signed [31:0] sum_reg, sum_next; // Running sum of samples.
  logic [15:0] cnt_reg, cnt_next; // Samples in the current window.
  logic [31:0] rem_reg, rem_next; // Divider remainder.
  logic [31:0] quo_reg, quo_next; // Divider dividend that turns into the quotient.
  logic [4:0] step_reg, step_next; // Divider step counter.
  logic neg_reg, neg_next; // Sign of the sum being divided.
  logic signed [15:0] avg_reg, avg_next; // Last finished average.
  logic valid_reg, valid_next; // One-cycle pulse with a new average.
  logic [15:0] target; // Window length, a zero time means a single sample.
  logic [31:0] trial; // Shifted remainder of this divider step.

  assign target = (time_ms == 16'h0000) ? 16'h0001 : time_ms;
  assign trial = {rem_reg[30:0], quo_reg[31]};
  assign avg = avg_reg;
  assign avg_valid = valid_reg;

  // Next-state logic: accumulate, then a restoring division; a dropped run flushes the window.
  always_comb
  begin
    state_next = state_reg;
    sum_next = sum_reg;
    cnt_next = cnt_reg;
    rem_next = rem_reg;
    quo_next = quo_reg;
    step_next = step_reg;
    neg_next = neg_reg;
    avg_next = avg_reg;
    valid_next = 1'b0;
    if (!run)
    begin
      // Leaving the window discards partial sums so the next window starts clean.
      state_next = AV_ACC;
      sum_next = 32'sh00000000;
      cnt_next = 16'h0000;
    end
    else if (state_reg == AV_ACC)
    begin
      if (tick_ms)
      begin
        sum_next = sum_reg + 32'(sample);
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_reg + 16'h0001 >= target)
        begin
          state_next = AV_DIV;
          neg_next = sum_next[31];
          quo_next = sum_next[31] ? 32'(-sum_next) : 32'(sum_next);
          rem_next = 32'h00000000;
          step_next = 5'h00;
        end
      end
    end
    else
    begin
      // One quotient bit per cycle; the window restarts once the quotient is out.
      quo_next = {quo_reg[30:0], 1'b0};
      rem_next = trial;
      if (trial >= {16'h0000, cnt_reg})
      begin
        rem_next = trial - {16'h0000, cnt_reg};
        quo_next = {quo_reg[30:0], 1'b1};
      end
      step_next = step_reg + 5'h01;
      if (step_reg == 5'(DIV_STEPS - 1))
      begin
        avg_next = neg_reg ? -$signed(quo_next[15:0]) : $signed(quo_next[15:0]);
        valid_next = 1'b1;
        state_next = AV_ACC;
        sum_next = 32'sh00000000;
        cnt_next = 16'h0000;
      end
    end
  end

  // Register stage of the averager.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= AV_ACC;
      sum_reg <= 32'sh00000000;
      cnt_reg <= 16'h0000;
      rem_reg <= 32'h00000000;
      quo_reg <= 32'h00000000;
      step_reg <= 5'h00;
      neg_reg <= 1'b0;
      avg_reg <= 16'sh0000;
      valid_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      sum_reg <= sum_next;
      cnt_reg <= cnt_next;
      rem_reg <= rem_next;
      quo_reg <= quo_next;
      step_reg <= step_next;
      neg_reg <= neg_next;
      avg_reg <= avg_next;
      valid_reg <= valid_next;
    end
  end

endmodule : torque_averager
`default_nettype wire

//--- rtl/load_deterioration_diagnosis.sv
// Deterioration diagnosis judgment block with a classic Wishbone register slave.
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`default_nettype none
module load_deterioration_diagnosis
  import diag_pkg::*;
#(
  parameter int MS_CYCLES = CYCLES_PER_MS
)
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADDR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [DATA_W-1:0] WB_DAT_I,
  output logic [DATA_W-1:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic POWER_UP_LOAD,
  input wire logic ESTIMATE_CONVERGED,
  input wire logic signed [15:0] DYN_FRICTION_EST,
  input wire logic [15:0] VISC_FRICTION_EST,
  input wire logic signed [15:0] MOTOR_SPEED,
  input wire logic signed [15:0] TORQUE_CMD,
  output logic DIAG_VELOCITY_WINDOW_OUT,
  output logic DIAG_WARNING,
  output logic IRQ
);

  import diag_pkg::*;

  // Width of the millisecond prescaler.
  localparam int MS_W = $clog2(MS_CYCLES + 1);

  // Parameter index names for the limit and setpoint array.
  localparam int P_DYN_UP = 0;
  localparam int P_DYN_LO = 1;
  localparam int P_VISC_UP = 2;
  localparam int P_VISC_LO = 3;
  localparam int P_SPEED = 4;
  localparam int P_TIME = 5;
  localparam int P_TQ_UP = 6;
  localparam int P_TQ_LO = 7;

  // Merges a write into a 16-bit register honouring the two low byte lanes.
  function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] dat, input logic [3:0] sel);
    lane_merge = old;
    if (sel[0])
    begin
      lane_merge[7:0] = dat[7:0];
    end
    if (sel[1])
    begin
      lane_merge[15:8] = dat[15:8];
    end
  endfunction : lane_merge

  // Out-of-band test of a signed value against an upper and a lower limit.
  function automatic logic out_of_band(input logic signed [15:0] val, input logic signed [15:0] up,
                                       input logic signed [15:0] lo);
    out_of_band = (val > up) || (val < lo);
  endfunction : out_of_band

  logic [15:0] param_reg [NUM_PARAM]; // Limits, setpoint and averaging time.
  logic [15:0] param_next [NUM_PARAM];
  logic [15:0] cfg_pend_reg, cfg_pend_next; // Configuration as last written by software.
  logic [15:0] cfg_act_reg, cfg_act_next; // Configuration in force since power-up.
  logic [15:0] match_w_reg, match_w_next; // Velocity match width in r/min.
  logic [NUM_EVENTS-1:0] status_reg, status_next; // Sticky event bits.
  logic [NUM_EVENTS-1:0] mask_reg, mask_next; // Interrupt enables per event.
  logic ack_reg, ack_next; // Bus acknowledge, one cycle.
  logic [DATA_W-1:0] dat_reg, dat_next; // Registered read data.
  logic [MS_W-1:0] ms_cnt_reg, ms_cnt_next; // Millisecond prescaler.
  logic win_reg, win_next; // Velocity window output.
  logic dyn_bad_reg, dyn_bad_next; // Dynamic friction outside its band.
  logic visc_bad_reg, visc_bad_next; // Viscous friction outside its band.
  logic tq_bad_reg, tq_bad_next; // Torque average outside its band.
  logic signed [15:0] tq_avg; // Latest torque average.
  logic tq_avg_valid; // Pulse with a new torque average.
  logic tick_ms; // One-cycle millisecond strobe.
  logic diag_en; // Diagnosis warning enable in force.
  logic bus_req; // A new bus cycle is waiting for its ack.
  logic wr_req; // That cycle is a write.
  logic rd_status; // That cycle reads the status register.
  logic signed [17:0] speed_diff; // Speed minus setpoint, wide enough not to wrap.
  logic [17:0] speed_abs; // Magnitude of that difference.
  logic [NUM_EVENTS-1:0] ev_set; // Rising events this cycle.

  assign diag_en = cfg_act_reg[CFG_DIAG_EN_BIT];
  assign bus_req = WB_CYC_I && WB_STB_I && !ack_reg;
  assign wr_req = bus_req && WB_WE_I;
  assign rd_status = bus_req && !WB_WE_I && (WB_ADR_I == OFF_STATUS);
  assign tick_ms = (ms_cnt_reg == MS_W'(MS_CYCLES - 1));
  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = dat_reg;
  assign DIAG_VELOCITY_WINDOW_OUT = win_reg;
  assign DIAG_WARNING = dyn_bad_reg || visc_bad_reg || tq_bad_reg;
  assign IRQ = |(status_reg & mask_reg);

  // Parameter registers: a write on byte lane 0 or 1 updates the addressed one immediately.
  generate
    for (genvar i = 0; i < NUM_PARAM; i++)
    begin : g_param
      always_comb
      begin
        param_next[i] = param_reg[i];
        if (wr_req && (WB_ADR_I == ADDR_W'(4 * i)))
        begin
          param_next[i] = lane_merge(param_reg[i], WB_DAT_I, WB_SEL_I);
        end
      end

      // The limits reset to zero, which makes any nonzero estimate a violation until set.
      always_ff @(posedge CLK or posedge RST)
      begin
        if (RST)
        begin
          param_reg[i] <= PARAM_RESET;
        end
        else
        begin
          param_reg[i] <= param_next[i];
        end
      end
    end
  endgenerate

  // Control registers, bus answer and the read mux.
  always_comb
  begin
    cfg_pend_next = cfg_pend_reg;
    cfg_act_next = cfg_act_reg;
    match_w_next = match_w_reg;
    mask_next = mask_reg;
    ack_next = bus_req;
    dat_next = dat_reg;
    if (wr_req)
    begin
      if (WB_ADR_I == OFF_CONFIG)
      begin
        // Configuration is held pending; it only acts after the next power-up.
        cfg_pend_next = lane_merge(cfg_pend_reg, WB_DAT_I, WB_SEL_I);
      end
      else if (WB_ADR_I == OFF_MATCH_W)
      begin
        match_w_next = lane_merge(match_w_reg, WB_DAT_I, WB_SEL_I);
      end
      else if (WB_ADR_I == OFF_MASK)
      begin
        if (WB_SEL_I[0])
        begin
          mask_next = WB_DAT_I[NUM_EVENTS-1:0];
        end
      end
    end
    if (POWER_UP_LOAD)
    begin
      cfg_act_next = cfg_pend_reg;
    end
    if (bus_req && !WB_WE_I)
    begin
      // Read mux; below 0x20 the low address bits are ignored, other unmapped addresses read as zero and are still acknowledged.
      if (WB_ADR_I < ADDR_W'(4 * NUM_PARAM))
      begin
        dat_next = {16'h0000, param_reg[WB_ADR_I[4:2]]};
      end
      else if (WB_ADR_I == OFF_CONFIG)
      begin
        dat_next = {cfg_act_reg, cfg_pend_reg};
      end
      else if (WB_ADR_I == OFF_MATCH_W)
      begin
        dat_next = {16'h0000, match_w_reg};
      end
      else if (WB_ADR_I == OFF_STATUS)
      begin
        dat_next = {28'h0000000, status_reg};
      end
      else if (WB_ADR_I == OFF_MASK)
      begin
        dat_next = {28'h0000000, mask_reg};
      end
      else if (WB_ADR_I == OFF_STATE)
      begin
        dat_next = {tq_avg, 10'h000, ESTIMATE_CONVERGED, diag_en, tq_bad_reg, visc_bad_reg, dyn_bad_reg, win_reg};
      end
      else
      begin
        dat_next = 32'h00000000;
      end
    end
  end

  // Control register stage.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      cfg_pend_reg <= CONFIG_RESET;
      cfg_act_reg <= CONFIG_RESET;
      match_w_reg <= MATCH_W_RESET;
      mask_reg <= MASK_RESET;
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end
    else
    begin
      cfg_pend_reg <= cfg_pend_next;
      cfg_act_reg <= cfg_act_next;
      match_w_reg <= match_w_next;
      mask_reg <= mask_next;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  // Judgment logic: velocity window, friction bands and the torque band.
  always_comb
  begin
    speed_diff = 18'(MOTOR_SPEED) - 18'($signed(param_reg[P_SPEED]));
    speed_abs = speed_diff[17] ? 18'(-speed_diff) : 18'(speed_diff);
    win_next = diag_en && (speed_abs <= {2'b00, match_w_reg});
    dyn_bad_next = 1'b0;
    visc_bad_next = 1'b0;
    if (diag_en && ESTIMATE_CONVERGED)
    begin
      dyn_bad_next = out_of_band(DYN_FRICTION_EST, param_reg[P_DYN_UP], param_reg[P_DYN_LO]);
      visc_bad_next = (VISC_FRICTION_EST > param_reg[P_VISC_UP]) || (VISC_FRICTION_EST < param_reg[P_VISC_LO]);
    end
    tq_bad_next = tq_bad_reg;
    if (!(diag_en && win_reg))
    begin
      // The torque verdict belongs to the window it was taken in.
      tq_bad_next = 1'b0;
    end
    else if (tq_avg_valid)
    begin
      tq_bad_next = out_of_band(tq_avg, param_reg[P_TQ_UP], param_reg[P_TQ_LO]);
    end
    ms_cnt_next = tick_ms ? '0 : ms_cnt_reg + MS_W'(1);
  end

  // Judgment register stage.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      win_reg <= 1'b0;
      dyn_bad_reg <= 1'b0;
      visc_bad_reg <= 1'b0;
      tq_bad_reg <= 1'b0;
      ms_cnt_reg <= '0;
    end
    else
    begin
      win_reg <= win_next;
      dyn_bad_reg <= dyn_bad_next;
      visc_bad_reg <= visc_bad_next;
      tq_bad_reg <= tq_bad_next;
      ms_cnt_reg <= ms_cnt_next;
    end
  end

  // Torque averaging runs only while diagnosis is on and the window output is on.
  torque_averager u_avg (
    .clk(CLK),
    .rst(RST),
    .run(diag_en && win_reg),
    .tick_ms(tick_ms),
    .time_ms(param_reg[P_TIME]),
    .sample(TORQUE_CMD),
    .avg(tq_avg),
    .avg_valid(tq_avg_valid)
  );

  // Sticky status: rising edges of each condition; a set in the clearing cycle survives.
  always_comb
  begin
    ev_set = '0;
    ev_set[ST_DYN_BIT] = dyn_bad_next && !dyn_bad_reg;
    ev_set[ST_VISC_BIT] = visc_bad_next && !visc_bad_reg;
    ev_set[ST_TQ_BIT] = tq_bad_next && !tq_bad_reg;
    ev_set[ST_WIN_BIT] = win_next && !win_reg;
    status_next = (rd_status ? '0 : status_reg) | ev_set;
  end

  // Status register stage.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      status_reg <= '0;
    end
    else
    begin
      status_reg <= status_next;
    end
  end

endmodule : load_deterioration_diagnosis
`default_nettype wire

//--- sim/host_monitor.sv
// Host controller model that watches the diagnosis velocity output.
`default_nettype none
module host_monitor
(
  input wire logic clk,
  input wire logic rst,
  input wire logic win,
  output int entries
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_reg; // Previous level, so only entries are counted.

  // The host counts each time the window output turns on.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      last_reg <= 1'b0;
      entries <= 0;
    end
    else
    begin
      last_reg <= win;
      if (win && !last_reg)
        entries <= entries + 1;
    end
  end
endmodule : host_monitor
`default_nettype wire

//--- sim/diag_sva.sv
// Checker for the diagnosis block, watching its ports only.
`default_nettype none
module diag_sva
  import diag_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [ADDR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [DATA_W-1:0] WB_DAT_I,
  input wire logic [DATA_W-1:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic POWER_UP_LOAD,
  input wire logic ESTIMATE_CONVERGED,
  input wire logic signed [15:0] DYN_FRICTION_EST,
  input wire logic [15:0] VISC_FRICTION_EST,
  input wire logic signed [15:0] MOTOR_SPEED,
  input wire logic signed [15:0] TORQUE_CMD,
  input wire logic DIAG_VELOCITY_WINDOW_OUT,
  input wire logic DIAG_WARNING,
  input wire logic IRQ
);
  logic [15:0] sh_reg [0:9]; // Shadow of the words at 0x00 to 0x24.
  logic [15:0] act_reg; // Shadow of the active configuration.
  logic [3:0] msk_reg; // Shadow of the mask.
  logic [15:0] exp_reg; // Word a pending read should return.
  logic rd_reg; // A parameter read is pending.
  logic hi_reg; // An unmapped read is pending.
  logic take; // A request is taken at this edge.
  logic en; // Diagnosis enable as the device uses it.
  logic signed [17:0] dv; // Speed minus setpoint, without overflow.
  logic signed [17:0] w; // Match width as a signed value.
  logic win_exp; // Window condition at this edge.
  logic fric_bad; // A friction estimate is out of band.
  assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign en = act_reg[CFG_DIAG_EN_BIT];
  assign dv = 18'(MOTOR_SPEED) - 18'($signed(sh_reg[4]));
  assign w = $signed({2'b00, sh_reg[9]});
  assign win_exp = en && (dv <= w) && (-dv <= w);
  assign fric_bad = en && ESTIMATE_CONVERGED && (DYN_FRICTION_EST > $signed(sh_reg[0])
    || DYN_FRICTION_EST < $signed(sh_reg[1]) || VISC_FRICTION_EST > sh_reg[2] || VISC_FRICTION_EST < sh_reg[3]);

  // Shadows follow full-word writes; the bench always writes all lanes.
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      for (int i = 0; i < 10; i++)
        sh_reg[i] <= 16'h0000;
      act_reg <= 16'h0000;
      msk_reg <= 4'h0;
      exp_reg <= 16'h0000;
      rd_reg <= 1'b0;
      hi_reg <= 1'b0;
    end
    else
    begin
      if (take && WB_WE_I && WB_ADR_I[7:2] < 6'd10)
        sh_reg[WB_ADR_I[5:2]] <= WB_DAT_I[15:0];
      if (take && WB_WE_I && WB_ADR_I == OFF_MASK && WB_SEL_I[0])
        msk_reg <= WB_DAT_I[3:0];
      if (POWER_UP_LOAD)
        act_reg <= sh_reg[8];
      exp_reg <= sh_reg[WB_ADR_I[5:2]];
      rd_reg <= take && !WB_WE_I && WB_ADR_I < OFF_CONFIG;
      hi_reg <= take && !WB_WE_I && WB_ADR_I > OFF_STATE;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  a_ack_next: assert property (take |=> WB_ACK_O) else $error("ack late");
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  a_ack_cause: assert property (WB_ACK_O |-> $past(take)) else $error("ack without request");
  a_read_back: assert property (WB_ACK_O && rd_reg |-> WB_DAT_O[15:0] == exp_reg) else $error("bad read");
  a_unmapped_zero: assert property (WB_ACK_O && hi_reg |-> WB_DAT_O == 32'h0) else $error("unmapped data");
  a_window_match: assert property (1'b1 |-> DIAG_VELOCITY_WINDOW_OUT == $past(win_exp)) else $error("window");
  a_window_enable: assert property (DIAG_VELOCITY_WINDOW_OUT |-> $past(en)) else $error("window off");
  a_fric_warn: assert property ($past(fric_bad) |-> DIAG_WARNING) else $error("no warning");
  a_warn_quiet: assert property (!DIAG_VELOCITY_WINDOW_OUT && !$past(DIAG_VELOCITY_WINDOW_OUT) && !$past(fric_bad)
    |-> !DIAG_WARNING) else $error("stray warning");
  a_irq_masked: assert property (msk_reg == 4'h0 && $past(msk_reg == 4'h0) |-> !IRQ) else $error("irq masked");
  c_window: cover property ($rose(DIAG_VELOCITY_WINDOW_OUT));
  c_warn: cover property ($rose(DIAG_WARNING) && DIAG_VELOCITY_WINDOW_OUT);
  c_irq: cover property ($rose(IRQ));
  c_read: cover property (WB_ACK_O && rd_reg);
endmodule : diag_sva
`default_nettype wire

//--- sim/load_deterioration_diagnosis_bench.sv
// Self-checking bench for the deterioration diagnosis block.
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module load_deterioration_diagnosis_bench;
  import diag_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, cyc, stb, we, ack, pul, conv, win, warn, irq;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, dato, q;
  logic signed [15:0] dyn, spd, tq, su, sl, sp;
  logic [15:0] visc, vu, vl;
  int miscompares, tests_run, cycles, ent, seen;
  int seed = 32'h9EFE1C2B;
  int offs [5] = '{0, 100, 101, -100, -101}; // Edges of the window, width 100.

  load_deterioration_diagnosis #(.MS_CYCLES(10)) i_load_deterioration_diagnosis (.CLK(clk), .RST(rst),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
    .WB_DAT_O(dato), .WB_ACK_O(ack), .POWER_UP_LOAD(pul), .ESTIMATE_CONVERGED(conv),
    .DYN_FRICTION_EST(dyn), .VISC_FRICTION_EST(visc), .MOTOR_SPEED(spd), .TORQUE_CMD(tq),
    .DIAG_VELOCITY_WINDOW_OUT(win), .DIAG_WARNING(warn), .IRQ(irq));
  host_monitor i_host_monitor (.clk(clk), .rst(rst), .win(win), .entries(seen));

  // Random pick in a closed range from the fixed seed.
  function automatic int pick(input int lo, input int hi);
    pick = lo + (($random(seed)) & 32'h7FFFFFFF) % (hi - lo + 1);
  endfunction : pick

  // One classic cycle; the wait is bounded so a dead slave cannot hang the run.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    q = dato;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask : rd

  logic win_prev; // Window level the bench last expected, to count entries.

  // Moves the speed, lets the registered window settle, and checks it.
  task automatic go(input logic signed [15:0] s, input logic e);
    spd <= s;
    repeat (3) @(posedge clk);
    `CHK(win, e)
    if (e && !win_prev) ent++;
    win_prev = e;
  endtask : go

  // Waits a bounded time for the warning to reach a level.
  task automatic wait_warn(input logic e);
    int n;
    n = 0;
    do begin @(posedge clk); n++; end while (warn !== e && n < 400);
    `CHK(warn, e)
  endtask : wait_warn

  task automatic report_and_stop;
    if (miscompares == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The limit covers the whole sequence with a wide margin.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      miscompares++;
      report_and_stop;
    end
  end

  initial
  begin
    {cyc, stb, we, pul, conv, adr, dat, dyn, tq} = '0;
    sel = 4'hF; rst = 1'b1; win_prev = 1'b0; ent = 0;
    su = 16'(pick(1, 1000)); sl = 16'(-pick(1, 1000)); vu = 16'(pick(5001, 10000)); vl = 16'(pick(0, 5000));
    sp = 16'(pick(-15000, 15000)); visc = vl; spd = sp + 16'sd5000;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 8'h40; a += 4) rd(8'(a), 32'h0);
    bus(1'b1, OFF_DYN_UP, {16'h0, su}); bus(1'b1, OFF_DYN_LO, {16'h0, sl});
    bus(1'b1, OFF_VISC_UP, {16'h0, vu}); bus(1'b1, OFF_VISC_LO, {16'h0, vl});
    bus(1'b1, OFF_SPEED_SET, {16'h0, sp}); bus(1'b1, OFF_AVG_TIME, 32'h4);
    bus(1'b1, OFF_TQ_UP, 32'h64); bus(1'b1, OFF_TQ_LO, 32'hFF9C); bus(1'b1, OFF_MATCH_W, 32'h64);
    rd(OFF_DYN_UP, {16'h0, su}); rd(OFF_DYN_LO, {16'h0, sl});
    rd(OFF_VISC_UP, {16'h0, vu}); rd(OFF_VISC_LO, {16'h0, vl});
    bus(1'b1, OFF_MASK, 32'hF); bus(1'b1, OFF_CONFIG, 32'h2);
    rd(OFF_CONFIG, 32'h0000_0002);
    go(sp, 1'b0);
    pul <= 1'b1; @(posedge clk); pul <= 1'b0;
    rd(OFF_CONFIG, 32'h0002_0002);
    for (int i = 0; i < 5; i++) go(sp + 16'(offs[i]), i != 2 && i != 4);
    go(sp + 16'sd5000, 1'b0);
    dyn <= su + 16'sd1; repeat (3) @(posedge clk);
    `CHK(warn, 1'b0)
    conv <= 1'b1; repeat (3) @(posedge clk);
    `CHK(warn, 1'b1)
    dyn <= sl; repeat (3) @(posedge clk);
    `CHK(warn, 1'b0)
    visc <= vu + 16'd1; repeat (3) @(posedge clk);
    `CHK(warn, 1'b1)
    visc <= vu; tq <= 16'sd300;
    bus(1'b0, OFF_STATUS, 32'h0);
    go(sp, 1'b1);
    wait_warn(1'b1);
    tq <= -16'sd50; wait_warn(1'b0);
    tq <= -16'sd101; wait_warn(1'b1);
    `CHK(irq, 1'b1)
    bus(1'b0, OFF_STATUS, 32'h0);
    `CHK(q[ST_WIN_BIT], 1'b1)
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    bus(1'b1, OFF_MASK, 32'h0);
    go(sp + 16'sd500, 1'b0); go(sp, 1'b1);
    `CHK(irq, 1'b0)
    bus(1'b0, OFF_STATUS, 32'h0);
    `CHK(q[ST_WIN_BIT], 1'b1)
    bus(1'b1, 8'h40, 32'hFFFF); rd(8'h40, 32'h0);
    `CHK(seen, ent)
    report_and_stop;
  end
endmodule : load_deterioration_diagnosis_bench

bind load_deterioration_diagnosis diag_sva i_diag_sva (.CLK(CLK), .RST(RST), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .POWER_UP_LOAD(POWER_UP_LOAD), .ESTIMATE_CONVERGED(ESTIMATE_CONVERGED),
  .DYN_FRICTION_EST(DYN_FRICTION_EST), .VISC_FRICTION_EST(VISC_FRICTION_EST), .MOTOR_SPEED(MOTOR_SPEED),
  .TORQUE_CMD(TORQUE_CMD), .DIAG_VELOCITY_WINDOW_OUT(DIAG_VELOCITY_WINDOW_OUT), .DIAG_WARNING(DIAG_WARNING),
  .IRQ(IRQ));
`default_nettype wire
